//--- parallel_eeprom_read_page_write_bench.sv
`default_nettype none

module parallel_eeprom_read_page_write_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import pep_pkg::*;
    logic mclk = 0, reset_n = 0, req_valid = 0, load_valid = 0, clk_en = 1;
    pep_req_t req = '0;
    pep_load_t load = '0;
    logic req_ready, load_ready, rd_valid_q, done_q, busy, lockout, data_lines_oe_n_q;
    logic [7:0] rd_data_q, data_lines_out_q, bus;
    pep_pins_t pins_q;
    int errors = 0, tests_run = 0, done_cnt = 0, writes = 0, seed = 32'h1e5a;
    logic [7:0] expq [$];
    logic [7:0] shadow [int];

    pep_host #(.LOCKOUT_CYC(20), .PROG_CYC(30), .WINDOW_CYC(100)) DUT (
        .mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .req_valid(req_valid), .req_ready(req_ready),
        .req(req), .load_valid(load_valid), .load_ready(load_ready), .load(load), .rd_valid_q(rd_valid_q),
        .rd_data_q(rd_data_q), .done_q(done_q), .busy(busy), .lockout(lockout), .pins_q(pins_q),
        .data_lines_out_q(data_lines_out_q), .data_lines_oe_n_q(data_lines_oe_n_q), .data_lines_in(bus)
    );
    pep_mem_model memory (
        .mclk(mclk), .pins(pins_q), .host_data(data_lines_out_q), .host_oe_n(data_lines_oe_n_q), .bus(bus)
    );

    // Free-running clock
    initial
    begin
        forever #5 mclk = ~mclk;
    end

    // Clock enable dropped in about one cycle of eight
    always @(posedge mclk)
        clk_en <= ($random(seed) & 7) != 0;

    // Expected content: last write, else the start pattern
    function automatic logic [7:0] expect_at(int a);
        return shadow.exists(a) ? shadow[a] : (a[7:0] ^ 8'h5A);
    endfunction

    task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // One request, held until taken, then wait for idle
    task automatic issue(pep_kind_t k, logic [14:0] a, logic [7:0] d);
        int n;
        @(posedge mclk);
        req <= '{k, a, d};
        req_valid <= 1'b1;
        n = 0;
        do @(posedge mclk); while (!(req_ready === 1'b1 && clk_en === 1'b1) && ++n < 1000);
        req_valid <= 1'b0;
        chk("request taken", 1, n < 1000);
        if (k == PEP_READ) expq.push_back(expect_at(a));
        else writes++;
        n = 0;
        do @(posedge mclk); while (req_ready !== 1'b1 && ++n < 5000);
        chk("request finished", 1, n < 5000);
    endtask

    task automatic load1(logic [5:0] o, logic [7:0] d);
        int n;
        @(posedge mclk);
        load <= '{o, d};
        load_valid <= 1'b1;
        n = 0;
        do @(posedge mclk); while (!(load_ready === 1'b1 && clk_en === 1'b1) && ++n < 1000);
        load_valid <= 1'b0;
        chk("load taken", 1, n < 1000);
    endtask

    // Result watcher: compares read data with the oldest note
    always @(posedge mclk)
    begin
        if (done_q === 1'b1 && clk_en === 1'b1) done_cnt++;
        if (rd_valid_q === 1'b1 && clk_en === 1'b1) chk("read data", expq.pop_front(), rd_data_q);
    end

    // Hang guard
    initial
    begin
        #300000;
        errors++;
        results();
    end

    // Main sequence
    initial
    begin
        int a;
        logic [7:0] d;
        logic [8:0] pg;
        logic [5:0] offs [5] = '{6'h05, 6'h3F, 6'h00, 6'h21, 6'h05};
        logic [5:0] rds [6] = '{6'h00, 6'h05, 6'h3F, 6'h21, 6'h11, 6'h01};
        repeat (12) @(posedge mclk);
        chk("strobe idle in reset", 1, pins_q.write_strobe_n);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        chk("ready in lockout", 0, req_ready);
        chk("lockout flag", 1, lockout);
        chk("busy in lockout", 1, busy);
        chk("load ready in lockout", 0, load_ready);
        // Byte writes at random places, each read back
        for (int i = 0; i < 3; i++)
        begin
            a = $random(seed) & 32'h7FFF;
            d = $random(seed);
            issue(PEP_BYTE_WRITE, a[14:0], d);
            shadow[a] = d;
            issue(PEP_READ, a[14:0], 8'h00);
        end
        // Page loads out of order with one position reloaded
        pg = $random(seed);
        foreach (offs[j])
        begin
            d = $random(seed);
            load1(offs[j], d);
            shadow[int'({pg, offs[j]})] = d;
        end
        issue(PEP_PAGE_WRITE, {pg, 6'h11}, 8'hFF);
        foreach (rds[j]) issue(PEP_READ, {pg, rds[j]}, 8'h00);
        issue(PEP_READ, {pg + 9'h001, 6'h05}, 8'h00);
        // Page write with nothing loaded
        issue(PEP_PAGE_WRITE, 15'h0000, 8'h00);
        repeat (20) @(posedge mclk);
        chk("write done count", writes, done_cnt);
        chk("reads outstanding", 0, expq.size());
        chk("busy at end", 0, busy);
        chk("lockout at end", 0, lockout);
        results();
    end
endmodule

`default_nettype wire

//--- pep_host.sv
`default_nettype none

module pep_host #(
    parameter int LOCKOUT_CYC = pep_pkg::POWERUP_LOCKOUT_CYC,
    parameter int PROG_CYC = pep_pkg::PROGRAM_CYC,
    parameter int WINDOW_CYC = pep_pkg::BYTE_LOAD_WINDOW_CYC
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic req_valid,
    output logic req_ready,
    input wire pep_pkg::pep_req_t req,
    input wire logic load_valid,
    output logic load_ready,
    input wire pep_pkg::pep_load_t load,
    output logic rd_valid_q,
    output logic [pep_pkg::DATA_W-1:0] rd_data_q,
    output logic done_q,
    output logic busy,
    output logic lockout,
    output pep_pkg::pep_pins_t pins_q,
    output logic [pep_pkg::DATA_W-1:0] data_lines_out_q,
    output logic data_lines_oe_n_q,
    input wire logic [pep_pkg::DATA_W-1:0] data_lines_in
);
    import pep_pkg::*;

    typedef enum logic [3:0] {
        ST_LOCK, ST_IDLE, ST_READ, ST_SCAN, ST_FETCH, ST_LOW, ST_HOLD, ST_GAP, ST_BLC, ST_PROG
    } pep_state_t;

    pep_state_t state_q;
    logic [CNT_W-1:0] cnt_q;
    logic [PAGE_BYTES-1:0] mask_q;
    logic [OFFS_W-1:0] idx_q;
    logic [PAGE_W-1:0] page_q;
    logic [DATA_W-1:0] data_q;
    logic is_byte_q;
    logic [DATA_W-1:0] mem_rdata;

    function automatic logic reached(input logic [CNT_W-1:0] cnt, input int lim);
        reached = (cnt >= CNT_W'(lim - 1));
    endfunction

    // Decode of handshakes and scan state
    wire idle = (state_q == ST_IDLE);
    wire take = idle && req_valid;
    wire take_page = take && (req.kind == PEP_PAGE_WRITE) && (mask_q != '0);
    wire take_empty = take && (req.kind == PEP_PAGE_WRITE) && (mask_q == '0);
    wire take_byte = take && (req.kind == PEP_BYTE_WRITE);
    wire take_read = take && (req.kind == PEP_READ);
    wire load_take = load_valid && load_ready;
    wire slot_full = mask_q[idx_q];
    wire last_slot = (idx_q == OFFS_W'(PAGE_BYTES - 1));
    wire mem_rd = (state_q == ST_SCAN) && slot_full;

    assign req_ready = idle;
    assign load_ready = idle;
    assign busy = !idle;
    assign lockout = (state_q == ST_LOCK);

    // Staging store, last load wins
    pep_page_mem #(.DW(DATA_W), .AW(OFFS_W)) u_mem (
        .mclk(mclk),
        .clk_en(clk_en),
        .wr_en(load_take),
        .wr_addr(load.offset),
        .wr_data(load.data),
        .rd_en(mem_rd),
        .rd_addr(idx_q),
        .rd_data_q(mem_rdata)
    );

    // Cycle counter; reads as zero in the first cycle of every state
    pep_state_t cnt_state_q;
    wire [CNT_W-1:0] cnt_eff = (state_q != cnt_state_q) ? '0 : cnt_q;
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_q <= '0;
            cnt_state_q <= ST_LOCK;
        end
        else if (clk_en)
        begin
            cnt_q <= cnt_eff + CNT_W'(1);
            cnt_state_q <= state_q;
        end
    end

    // Loaded-position mask
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            mask_q <= '0;
        else if (clk_en)
        begin
            if (load_take)
                mask_q[load.offset] <= 1'b1;
            else if (state_q == ST_HOLD && !is_byte_q)
                mask_q[idx_q] <= 1'b0;
        end
    end

    // Main sequencer
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= ST_LOCK;
            idx_q <= '0;
            page_q <= '0;
            data_q <= '0;
            is_byte_q <= 1'b0;
            pins_q <= '{PIN_INACTIVE, PIN_INACTIVE, PIN_INACTIVE, '0};
            data_lines_out_q <= '0;
            data_lines_oe_n_q <= PIN_INACTIVE;
            rd_valid_q <= 1'b0;
            rd_data_q <= '0;
            done_q <= 1'b0;
        end
        else if (clk_en)
        begin
            rd_valid_q <= 1'b0;
            done_q <= 1'b0;
            case (state_q)
                ST_LOCK:
                    if (reached(cnt_eff, LOCKOUT_CYC))
                        state_q <= ST_IDLE;
                ST_IDLE:
                begin
                    idx_q <= '0;
                    if (take_read)
                    begin
                        pins_q.address_lines <= req.address;
                        pins_q.chip_sel_n <= 1'b0;
                        pins_q.output_drive_n <= 1'b0;
                        state_q <= ST_READ;
                    end
                    else if (take_byte)
                    begin
                        is_byte_q <= 1'b1;
                        pins_q.address_lines <= req.address;
                        data_lines_out_q <= req.data;
                        data_lines_oe_n_q <= 1'b0;
                        pins_q.chip_sel_n <= 1'b0;
                        pins_q.write_strobe_n <= 1'b0;
                        state_q <= ST_LOW;
                    end
                    else if (take_page)
                    begin
                        is_byte_q <= 1'b0;
                        page_q <= req.address[ADDR_W-1:OFFS_W];
                        state_q <= ST_SCAN;
                    end
                    else if (take_empty)
                        done_q <= 1'b1;
                end
                ST_READ:
                    if (reached(cnt_eff, READ_ACCESS_CYC))
                    begin
                        rd_data_q <= data_lines_in;
                        rd_valid_q <= 1'b1;
                        pins_q.chip_sel_n <= 1'b1;
                        pins_q.output_drive_n <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                ST_SCAN:
                    if (slot_full)
                        state_q <= ST_FETCH;
                    else if (last_slot)
                        state_q <= ST_BLC;
                    else
                        idx_q <= idx_q + OFFS_W'(1);
                ST_FETCH:
                begin
                    pins_q.address_lines <= {page_q, idx_q};
                    data_lines_out_q <= mem_rdata;
                    data_lines_oe_n_q <= 1'b0;
                    pins_q.chip_sel_n <= 1'b0;
                    pins_q.write_strobe_n <= 1'b0;
                    state_q <= ST_LOW;
                end
                ST_LOW:
                    if (reached(cnt_eff, STROBE_LOW_CYC))
                    begin
                        pins_q.write_strobe_n <= 1'b1;
                        state_q <= ST_HOLD;
                    end
                ST_HOLD:
                begin
                    pins_q.chip_sel_n <= 1'b1;
                    data_lines_oe_n_q <= 1'b1;
                    state_q <= ST_GAP;
                end
                ST_GAP:
                    if (reached(cnt_eff, LOAD_GAP_CYC))
                    begin
                        if (is_byte_q || last_slot)
                            state_q <= ST_BLC;
                        else
                        begin
                            idx_q <= idx_q + OFFS_W'(1);
                            state_q <= ST_SCAN;
                        end
                    end
                ST_BLC:
                    if (reached(cnt_eff, WINDOW_CYC))
                        state_q <= ST_PROG;
                ST_PROG:
                    if (reached(cnt_eff, PROG_CYC))
                    begin
                        done_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // Run lengths of strobe levels, for checking only
    logic [CNT_W-1:0] low_run_q;
    logic [CNT_W-1:0] high_run_q;
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            low_run_q <= '0;
            high_run_q <= '0;
        end
        else if (clk_en)
        begin
            low_run_q <= pins_q.write_strobe_n ? '0 : low_run_q + CNT_W'(1);
            high_run_q <= (!pins_q.write_strobe_n || idle) ? '0 : high_run_q + CNT_W'(1);
        end
    end

    a_write_combo: assert property (@(posedge mclk) disable iff (!reset_n)
        !pins_q.write_strobe_n |-> !pins_q.chip_sel_n && pins_q.output_drive_n)
        else $error("strobe low without select low and output drive high");
    a_read_combo: assert property (@(posedge mclk) disable iff (!reset_n)
        !pins_q.output_drive_n |-> pins_q.write_strobe_n && !pins_q.chip_sel_n)
        else $error("read drive without select or with strobe low");
    a_data_release: assert property (@(posedge mclk) disable iff (!reset_n)
        !pins_q.output_drive_n |-> data_lines_oe_n_q)
        else $error("host drives data lines during a read");
    a_strobe_width: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(pins_q.write_strobe_n) |-> $past(low_run_q) >= CNT_W'(STROBE_LOW_CYC - 1))
        else $error("strobe low pulse too short");
    a_addr_stable: assert property (@(posedge mclk) disable iff (!reset_n)
        !pins_q.write_strobe_n && $past(!pins_q.write_strobe_n) |-> $stable(pins_q.address_lines))
        else $error("address moved while strobe low");
    a_data_hold: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(pins_q.write_strobe_n) |-> !data_lines_oe_n_q && $stable(data_lines_out_q))
        else $error("data not held across strobe rise");
    a_page_same: assert property (@(posedge mclk) disable iff (!reset_n)
        $fell(pins_q.write_strobe_n) && !is_byte_q |-> pins_q.address_lines[ADDR_W-1:OFFS_W] == page_q)
        else $error("page address changed inside a page sequence");
    a_gap_window: assert property (@(posedge mclk) disable iff (!reset_n)
        $fell(pins_q.write_strobe_n) && state_q == ST_LOW && !is_byte_q
        |-> $past(high_run_q) < CNT_W'(WINDOW_CYC))
        else $error("byte load gap exceeded the window");
    a_blc_hold: assert property (@(posedge mclk) disable iff (!reset_n)
        state_q == ST_PROG && $past(state_q) == ST_BLC |-> $past(high_run_q) >= CNT_W'(WINDOW_CYC - 1))
        else $error("program phase entered before window elapsed");
    a_lock_nowrite: assert property (@(posedge mclk) disable iff (!reset_n)
        state_q == ST_LOCK |-> pins_q.write_strobe_n && load_ready == 1'b0)
        else $error("write activity during power-up lockout");

endmodule

`default_nettype wire

//--- pep_mem_model.sv
`default_nettype none

// Behavioural memory that answers the host on its pins
module pep_mem_model #(
    parameter int WINDOW = 100,
    parameter int PROG = 30,
    parameter int LOCK = 25
) (
    input wire logic mclk,
    input wire pep_pkg::pep_pins_t pins,
    input wire logic [7:0] host_data,
    input wire logic host_oe_n,
    output logic [7:0] bus
);
    timeunit 1ns;
    timeprecision 1ps;
    import pep_pkg::*;
    logic [7:0] mem [0:32767];
    logic [7:0] page_buf [0:63];
    logic [63:0] loaded = '0;
    logic [14:0] addr_lat = '0;
    logic [8:0] page = '0;
    logic [7:0] last_drive = '0, data_prev = '0, last_data = '0, rd_val;
    logic wr_prev = 0, timing = 0, toggle = 0;
    int low_cyc = 0, timer = 0, prog_left = 0, age = 0;
    wire wr_now = !pins.chip_sel_n && !pins.write_strobe_n && pins.output_drive_n;
    wire rd_now = !pins.chip_sel_n && !pins.output_drive_n && pins.write_strobe_n;

    // Known start pattern, mirrored by the bench
    initial
    begin
        for (int i = 0; i < 32768; i++) mem[i] = i[7:0] ^ 8'h5A;
    end

    // Status bits while busy, stored byte otherwise
    always_comb rd_val = (prog_left > 0) ? {~last_data[7], toggle, 6'h00} : mem[pins.address_lines];
    // Released bus flips every cycle so a stale value cannot pass
    always_comb bus = !host_oe_n ? host_data : rd_now ? rd_val : ~last_drive;

    // Latching, page buffer, load timer and program cycle
    always @(posedge mclk)
    begin
        age <= age + 1;
        last_drive <= bus;
        data_prev <= bus;
        wr_prev <= wr_now;
        low_cyc <= wr_now ? low_cyc + 1 : 0;
        if (wr_now && !wr_prev)
        begin
            addr_lat <= pins.address_lines;
            timing <= 0;
        end
        else if (!wr_now && wr_prev && low_cyc >= 2 && age >= LOCK && prog_left == 0)
        begin
            page_buf[addr_lat[5:0]] <= data_prev;
            loaded[addr_lat[5:0]] <= 1'b1;
            page <= addr_lat[14:6];
            last_data <= data_prev;
            timing <= 1;
            timer <= 0;
        end
        else if (timing)
        begin
            timer <= timer + 1;
            if (timer == WINDOW)
            begin
                for (int i = 0; i < 64; i++)
                    if (loaded[i]) mem[{page, i[5:0]}] <= page_buf[i];
                loaded <= '0;
                timing <= 0;
                prog_left <= PROG;
            end
        end
        if (prog_left > 0)
        begin
            prog_left <= prog_left - 1;
            toggle <= ~toggle;
        end
    end
endmodule

`default_nettype wire

//--- pep_page_mem.sv
`default_nettype none

module pep_page_mem #(
    parameter int DW = 8,
    parameter int AW = 6
) (
    input wire logic mclk,
    input wire logic clk_en,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data_q
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    // Staging array with registered read port
    always_ff @(posedge mclk)
    begin
        if (clk_en && wr_en)
            mem[wr_addr] <= wr_data;
        if (clk_en && rd_en)
            rd_data_q <= mem[rd_addr];
    end

endmodule

`default_nettype wire

//--- pep_pkg.sv
`default_nettype none

package pep_pkg;

    // Clock and page geometry
    localparam int CLK_PERIOD_NS = 10;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int OFFS_W = 6;
    localparam int PAGE_W = ADDR_W - OFFS_W;
    localparam int PAGE_BYTES = 64;

    // Device timing figures in their own units
    localparam int T_STROBE_LOW_NS = 100;
    localparam int T_READ_ACCESS_NS = 150;
    localparam int T_LOAD_GAP_MIN_NS = 100;
    localparam int T_BYTE_LOAD_WINDOW_US = 100;
    localparam int T_PROGRAM_MS = 5;
    localparam int T_POWERUP_LOCKOUT_MS = 10;

    // Cycle counts, least times rounded up
    localparam int STROBE_LOW_CYC = (T_STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_ACCESS_CYC = (T_READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOAD_GAP_CYC = (T_LOAD_GAP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BYTE_LOAD_WINDOW_CYC = (T_BYTE_LOAD_WINDOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROGRAM_CYC = (T_PROGRAM_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWERUP_LOCKOUT_CYC = (T_POWERUP_LOCKOUT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 24;

    // Idle pin levels
    localparam logic PIN_INACTIVE = 1'b1;

    // User request kinds
    typedef enum logic [1:0] {PEP_READ, PEP_BYTE_WRITE, PEP_PAGE_WRITE} pep_kind_t;

    typedef struct packed {
        pep_kind_t kind;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] data;
    } pep_req_t;

    typedef struct packed {
        logic [OFFS_W-1:0] offset;
        logic [DATA_W-1:0] data;
    } pep_load_t;

    // Control pins toward the memory
    typedef struct packed {
        logic chip_sel_n;
        logic write_strobe_n;
        logic output_drive_n;
        logic [ADDR_W-1:0] address_lines;
    } pep_pins_t;

endpackage

`default_nettype wire
